// ===== hw/adcop_regs.svh
`ifndef ADCOP_REGS_SVH
`define ADCOP_REGS_SVH

// result word width and pipeline latency in encode cycles
`define ADCOP_CODE_W      12
`define ADCOP_LATENCY     5
// synchroniser depth for pins from outside the clock domain
`define ADCOP_SYNC_DEPTH  3
// width of the digitised input model, sign included
`define ADCOP_INPUT_W     14
// reset values of the output pins
`define ADCOP_RST_WORD    12'h000
`define ADCOP_RST_OVF     1'b0
`define ADCOP_RST_STROBE  1'b0

`endif

// ===== hw/adcop_pkg.sv
package adcop_pkg;

  // data valid strobe phase, one-hot
  typedef enum logic [1:0] {
    ADCOP_STROBE_LOW  = 2'b01,
    ADCOP_STROBE_HIGH = 2'b10
  } adcop_strobe_t;

endpackage

// ===== hw/adcop_pipe_if.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcop_regs.svh"

interface adcop_pipe_if;
  logic                       take;
  logic [`ADCOP_CODE_W-1:0]   code_in;
  logic                       ovf_in;
  logic [`ADCOP_CODE_W-1:0]   code_out;
  logic                       ovf_out;

  modport producer (
    output take,
    output code_in,
    output ovf_in,
    input  code_out,
    input  ovf_out
  );
  modport pipe (
    input  take,
    input  code_in,
    input  ovf_in,
    output code_out,
    output ovf_out
  );
endinterface

`default_nettype wire

// ===== hw/adcop_pipe.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcop_regs.svh"

module adcop_pipe #(
  parameter int LATENCY = `ADCOP_LATENCY
) (
  // clock and reset
  input  wire logic   clock,
  input  wire logic   reset_n,
  // stage link
  adcop_pipe_if.pipe  pif
);

  // refused at elaboration: the shift needs a head and a tail stage
  if (LATENCY < 2) begin : g_latency_check
    $error("adcop_pipe: LATENCY must be at least 2");
  end

  logic [`ADCOP_CODE_W-1:0] code_ff     [LATENCY];
  logic [`ADCOP_CODE_W-1:0] nxt_code    [LATENCY];
  logic [LATENCY-1:0]       ovf_ff;
  logic [LATENCY-1:0]       nxt_ovf;

  // shift one stage per taken sample; idle between encode edges
  always_comb begin
    nxt_code = code_ff;
    nxt_ovf  = ovf_ff;
    if (pif.take) begin
      nxt_code[0] = pif.code_in;
      nxt_ovf[0]  = pif.ovf_in;
      for (int i = 1; i < LATENCY; i++) begin
        nxt_code[i] = code_ff[i-1];
        nxt_ovf[i]  = ovf_ff[i-1];
      end
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < LATENCY; i++) begin
        code_ff[i] <= `ADCOP_RST_WORD;
      end
      ovf_ff <= '0;
    end else begin
      code_ff <= nxt_code;
      ovf_ff  <= nxt_ovf;
    end
  end

  // oldest stage: sample taken LATENCY-1 edges ago, shown on the next edge
  assign pif.code_out = code_ff[LATENCY-1];
  assign pif.ovf_out  = ovf_ff[LATENCY-1];

endmodule

`default_nettype wire

// ===== hw/adcop_top.sv
// Operation
// - low format select inverts the result msb (two's complement); high leaves offset binary
// - a new sample is taken on each rising encode edge (complement falling)
// - result word enabled while output enable is low, released while high; overflow flag and strobe always driven
// - overflow flag goes high for a result whose input left the convertible range
// - each result is a 12-bit parallel word, bits zero to eleven
// - with format select low, all-zeros and all-ones codes sit adjacent at the bipolar zero transition
// - a sample's result appears five encode cycles after it was taken
`timescale 1ns/100ps
`default_nettype none
`include "adcop_regs.svh"

module adcop_top #(
  parameter int INPUT_W = `ADCOP_INPUT_W,
  parameter int LATENCY = `ADCOP_LATENCY
) (
  // clock and reset
  input  wire logic                      clock,
  input  wire logic                      reset_n,
  // encode pins, differential
  input  wire logic                      encode_clock_input,
  input  wire logic                      encode_clock_comp,
  // digitised analog input, signed, one lsb per code
  input  wire logic [INPUT_W-1:0]        analog_sample,
  // static controls
  input  wire logic                      output_format_select,
  input  wire logic                      output_enable_n,
  // result pins
  output logic [`ADCOP_CODE_W-1:0]       result_word,
  output logic                           result_word_oe,
  output logic                           range_overflow_flag,
  output logic                           data_valid_strobe
);

  localparam int NPIN         = 4;
  localparam int PIN_ENCODE   = 0;
  localparam int PIN_ENCODE_C = 1;
  localparam int PIN_FMT      = 2;
  localparam int PIN_OEN      = 3;

  // refused at elaboration: clamping needs headroom above the code width
  if (INPUT_W <= `ADCOP_CODE_W) begin : g_input_w_check
    $error("adcop_top: INPUT_W must exceed the code width to show overflow");
  end

  // clamp a signed input to the code range and return {overflow, offset binary code}
  function automatic logic [`ADCOP_CODE_W:0] adcop_convert(input logic [INPUT_W-1:0] s);
    logic signed [INPUT_W-1:0] v;
    logic signed [INPUT_W-1:0] hi;
    logic signed [INPUT_W-1:0] lo;
    logic [`ADCOP_CODE_W-1:0]  c;
    logic                      ovf;
    v   = signed'(s);
    hi  = INPUT_W'((1 << (`ADCOP_CODE_W - 1)) - 1);
    lo  = -hi - INPUT_W'(1);
    ovf = 1'b0;
    if (v > hi) begin
      c   = hi[`ADCOP_CODE_W-1:0];
      ovf = 1'b1;
    end else if (v < lo) begin
      c   = lo[`ADCOP_CODE_W-1:0];
      ovf = 1'b1;
    end else begin
      c = v[`ADCOP_CODE_W-1:0];
    end
    // offset binary is two's complement with the msb flipped
    return {ovf, ~c[`ADCOP_CODE_W-1], c[`ADCOP_CODE_W-2:0]};
  endfunction

  // pin synchronisers
  logic [NPIN-1:0]    sync1_ff;
  logic [NPIN-1:0]    sync2_ff;
  logic [NPIN-1:0]    sync3_ff;
  logic [NPIN-1:0]    stable_ff;
  logic [NPIN-1:0]    nxt_stable;
  logic [INPUT_W-1:0] samp1_ff;
  logic [INPUT_W-1:0] samp2_ff;
  logic [INPUT_W-1:0] samp3_ff;
  logic [INPUT_W-1:0] sample_ff;
  logic [INPUT_W-1:0] nxt_sample;

  // a pin change counts once the second and third stages agree;
  // the sample bus gets the same depth so it stays aligned with the encode edge
  always_comb begin
    nxt_stable = (~(sync2_ff ^ sync3_ff) & sync3_ff) | ((sync2_ff ^ sync3_ff) & stable_ff);
    // a bus caught mid-change keeps the last agreed value
    nxt_sample = (samp2_ff == samp3_ff) ? samp3_ff : sample_ff;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      sync1_ff  <= '0;
      sync2_ff  <= '0;
      sync3_ff  <= '0;
      stable_ff <= '0;
      samp1_ff  <= '0;
      samp2_ff  <= '0;
      samp3_ff  <= '0;
      sample_ff <= '0;
    end else begin
      sync1_ff  <= {output_enable_n, output_format_select, encode_clock_comp,
                    encode_clock_input};
      sync2_ff  <= sync1_ff;
      sync3_ff  <= sync2_ff;
      stable_ff <= nxt_stable;
      samp1_ff  <= analog_sample;
      samp2_ff  <= samp1_ff;
      samp3_ff  <= samp2_ff;
      sample_ff <= nxt_sample;
    end
  end

  // encode edge detection
  logic encode_lvl_ff;
  logic nxt_encode_lvl;
  logic encode_rise;
  logic encode_fall;

  // differential level; equal pins keep the last level so noise cannot double-clock
  always_comb begin
    if (stable_ff[PIN_ENCODE] != stable_ff[PIN_ENCODE_C]) begin
      nxt_encode_lvl = stable_ff[PIN_ENCODE];
    end else begin
      nxt_encode_lvl = encode_lvl_ff;
    end
    encode_rise = nxt_encode_lvl & ~encode_lvl_ff;
    encode_fall = ~nxt_encode_lvl & encode_lvl_ff;
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      encode_lvl_ff <= 1'b0;
    end else begin
      encode_lvl_ff <= nxt_encode_lvl;
    end
  end

  // conversion pipeline
  adcop_pipe_if pif ();
  logic [`ADCOP_CODE_W:0] conv;

  // input is taken when the rising edge is seen; it must be steady around the edge
  always_comb begin
    conv        = adcop_convert(sample_ff);
    pif.take    = encode_rise;
    pif.code_in = conv[`ADCOP_CODE_W-1:0];
    pif.ovf_in  = conv[`ADCOP_CODE_W];
  end

  adcop_pipe #(
    .LATENCY (LATENCY)
  ) u_pipe (
    .clock   (clock),
    .reset_n (reset_n),
    .pif     (pif)
  );

  // output stage
  adcop_pkg::adcop_strobe_t    strobe_ff;
  adcop_pkg::adcop_strobe_t    nxt_strobe;
  logic [`ADCOP_CODE_W-1:0]    word_ff;
  logic [`ADCOP_CODE_W-1:0]    nxt_word;
  logic                        ovf_ff;
  logic                        nxt_ovf;
  logic                        oe_ff;
  logic                        nxt_oe;

  // word and flag change on the rising encode edge with the strobe low;
  // the strobe rises half an encode cycle later, mid-way through a stable word
  always_comb begin
    nxt_strobe = strobe_ff;
    nxt_word   = word_ff;
    nxt_ovf    = ovf_ff;
    nxt_oe     = ~stable_ff[PIN_OEN];
    case (strobe_ff)
      adcop_pkg::ADCOP_STROBE_LOW: begin
        if (encode_fall) begin
          nxt_strobe = adcop_pkg::ADCOP_STROBE_HIGH;
        end
      end
      adcop_pkg::ADCOP_STROBE_HIGH: begin
        if (encode_rise) begin
          nxt_strobe = adcop_pkg::ADCOP_STROBE_LOW;
        end
      end
      default: begin
        nxt_strobe = adcop_pkg::ADCOP_STROBE_LOW;
      end
    endcase
    if (encode_rise) begin
      // format low flips the msb so the codes wrap 000/FFF at zero
      nxt_word = {pif.code_out[`ADCOP_CODE_W-1] ^ ~stable_ff[PIN_FMT],
                  pif.code_out[`ADCOP_CODE_W-2:0]};
      nxt_ovf  = pif.ovf_out;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      strobe_ff <= adcop_pkg::ADCOP_STROBE_LOW;
      word_ff   <= `ADCOP_RST_WORD;
      ovf_ff    <= `ADCOP_RST_OVF;
      oe_ff     <= 1'b0;
    end else begin
      strobe_ff <= nxt_strobe;
      word_ff   <= nxt_word;
      ovf_ff    <= nxt_ovf;
      oe_ff     <= nxt_oe;
    end
  end

  // straight from flip-flops; the bench resolves the pad from the enable
  always_comb begin
    result_word         = word_ff;
    result_word_oe      = oe_ff;
    range_overflow_flag = ovf_ff;
    data_valid_strobe   = (strobe_ff == adcop_pkg::ADCOP_STROBE_HIGH);
  end

endmodule

`default_nettype wire

// ===== tb/adcop_asserts.sv
`timescale 1ns/100ps
`default_nettype none
`include "adcop_regs.svh"

module adcop_asserts #(
  parameter int INPUT_W = 14,
  parameter int LATENCY = 5
) (
  // clock and reset
  input wire logic                     clock,
  input wire logic                     reset_n,
  // encode pins and controls
  input wire logic                     encode_clock_input,
  input wire logic                     encode_clock_comp,
  input wire logic [INPUT_W-1:0]       analog_sample,
  input wire logic                     output_format_select,
  input wire logic                     output_enable_n,
  // result pins
  input wire logic [`ADCOP_CODE_W-1:0] result_word,
  input wire logic                     result_word_oe,
  input wire logic                     range_overflow_flag,
  input wire logic                     data_valid_strobe
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);

  // a word update that carries a clipped result
  sequence s_clip_update;
    $fell(data_valid_strobe) && range_overflow_flag;
  endsequence

  // pins sync over a few clocks, so only a settled pin is judged
  a_oe_follow: assert property (
    $stable(output_enable_n)[*7] |-> result_word_oe == !output_enable_n) else $error("oe lag");
  a_word_strobe_low: assert property (
    $changed({result_word, range_overflow_flag}) |-> !data_valid_strobe) else $error("word moved");
  a_strobe_rise_stable: assert property (
    $rose(data_valid_strobe) |=> $stable({result_word, range_overflow_flag})[*4])
    else $error("word unstable at strobe");
  a_rise_detect: assert property (
    $rose(encode_clock_input) && data_valid_strobe |-> ##[1:6] $fell(data_valid_strobe))
    else $error("encode rise missed");
  a_fall_detect: assert property (
    $fell(encode_clock_input) |-> ##[1:6] data_valid_strobe) else $error("strobe not raised");
  a_strobe_low_hold: assert property (
    $fell(data_valid_strobe) |=> !data_valid_strobe[*3]) else $error("strobe glitch");
  a_ovf_clamp: assert property (
    range_overflow_flag |-> result_word[10:0] inside {11'h7FF, 11'h000}) else $error("no clamp");
  // clamp code msb shows the format in force at the update
  a_fmt_clamp: assert property (
    $stable(output_format_select)[*6] ##0 s_clip_update
    |-> result_word[11] == (result_word[10] ^ !output_format_select)) else $error("msb format");
endmodule

bind adcop_top adcop_asserts #(.INPUT_W(INPUT_W), .LATENCY(LATENCY)) adcop_asserts_i (.*);

`default_nettype wire

// ===== tb/adcop_capture.sv
`timescale 1ns/100ps
`default_nettype none

module adcop_capture (
  // pins from the converter
  input wire logic        data_valid_strobe,
  input wire logic [11:0] result_pins,
  input wire logic        range_overflow_flag
);
  logic [12:0] words [$];

  // latch on the strobe edge, the only moment word and flag are promised
  always @(posedge data_valid_strobe) begin
    words.push_back({range_overflow_flag, result_pins});
  end
endmodule

`default_nettype wire

// ===== tb/tb_adc_parallel_output_port.sv
`timescale 1ns/100ps
`default_nettype none

module tb_adc_parallel_output_port;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  logic        encode_pin = 1'b0;
  logic [13:0] sample = 14'h0000;
  logic        fmt = 1'b0;
  logic        oe_n = 1'b0;
  logic [11:0] word;
  logic        word_oe;
  logic        ovf;
  logic        strobe;
  wire  [11:0] pins;
  int          fail_count = 0;
  int          checked = 0;
  int          cycles = 0;

  always #2 clock = ~clock;
  // encode pin: 20 clocks a half period, moved one step after the edge like every input
  initial begin
    forever begin
      repeat (20) step();
      encode_pin = ~encode_pin;
    end
  end
  // pad model: released pins float
  assign pins = word_oe ? word : 12'hZZZ;

  adcop_top adcop_top_i (.clock(clock), .reset_n(reset_n), .encode_clock_input(encode_pin),
    .encode_clock_comp(!encode_pin), .analog_sample(sample), .output_format_select(fmt),
    .output_enable_n(oe_n), .result_word(word), .result_word_oe(word_oe),
    .range_overflow_flag(ovf), .data_valid_strobe(strobe));
  adcop_capture adcop_capture_i (.data_valid_strobe(strobe), .result_pins(pins),
    .range_overflow_flag(ovf));

  task automatic step();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input logic [12:0] seen, input logic [12:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  // flag and code after clamping to the 12-bit range
  function automatic logic [12:0] expect_code(input int v, input logic f);
    int c;
    c = v > 2047 ? 2047 : (v < -2048 ? -2048 : v);
    return {c != v, 12'(c) ^ {f, 11'h000}};
  endfunction

  // new value mid low phase, clear of the rise; the word five rises on must show it
  task automatic apply(input int v, input int prev, input bit chk);
    int c0;
    @(negedge encode_pin);
    repeat (10) step();
    c0 = adcop_capture_i.words.size();
    sample = 14'(v);
    repeat (6) @(negedge encode_pin);
    repeat (10) step();
    if (chk) check(adcop_capture_i.words[c0 + 4], expect_code(prev, fmt));
    check(adcop_capture_i.words[c0 + 5], expect_code(v, fmt));
  endtask

  // range edges, clipping both ways, and the zero crossing
  task automatic t_codes(input logic f);
    int vals [8] = '{0, -1, 2047, 2048, -2048, -2049, -5000, 1};
    step();
    fmt = f;
    foreach (vals[i]) apply(vals[i], i ? vals[i-1] : 0, i != 0);
  endtask

  task automatic t_oe();
    step();
    oe_n = 1'b1;
    repeat (8) step();
    check({12'h000, word_oe}, 13'h0000);
    check({1'b0, pins}, {1'b0, 12'hZZZ});
    oe_n = 1'b0;
    repeat (8) step();
    check({12'h000, word_oe}, 13'h0001);
  endtask

  task automatic wrap_up();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // hang guard, well above the expected run length
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      wrap_up();
    end
  end

  initial begin
    repeat (8) step();
    reset_n = 1'b1;
    t_codes(1'b0);
    t_codes(1'b1);
    t_oe();
    wrap_up();
  end
endmodule

`default_nettype wire
